// ### core/acmp_pkg.sv
// What this block does
// - Power-on bit clear forces result low
// - Result bit read-only, mirrors comparator output
// - Exchange bit swaps inputs, inverts result
// - Reference on positive when select equals exchange
// - Level field: off, quarter, half, diode
// - Reference generator follows level field only
// - Flag on rising or falling edge chosen
// - Request needs flag, local and global enable
// - Flag cleared by service or software write
// - Filter bit picks filtered or unfiltered path
// - Pin connect bits attach pins to inputs
// - Port disable bit n disables buffer n
// - Result drives timer capture input
package acmp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL_ONE  = 8'h59;
  localparam logic [7:0] IDX_CTL_TWO  = 8'h5a;
  localparam logic [7:0] IDX_PORT_DIS = 8'h5b;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h5c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h5d;

  localparam logic [7:0] RST_CTL_ONE  = 8'h00;
  localparam logic [7:0] RST_CTL_TWO  = 8'h00;
  localparam logic [7:0] RST_PORT_DIS = 8'h00;
  localparam logic [7:0] RST_IRQ      = 8'h00;

  // Bits 7..1 of control two are stored; bit 0 is the live result
  localparam logic [7:0] CTL_TWO_WMASK = 8'hfe;

  // Control one fields
  localparam int B_EXCH   = 7;
  localparam int B_RSEL   = 6;
  localparam int B_REF_HI = 5;
  localparam int B_REF_LO = 4;
  localparam int B_ON     = 3;
  localparam int B_IES    = 2;
  localparam int B_IE     = 1;
  localparam int B_FLAG   = 0;

  // Control two fields
  localparam int B_PIN_ONE  = 3;
  localparam int B_PIN_ZERO = 2;
  localparam int B_FILT     = 1;
  localparam int B_RESULT   = 0;

  // Interrupt status bit for a selected result edge
  localparam int B_STAT_EDGE = 0;

  localparam logic [1:0] REF_OFF     = 2'h0;
  localparam logic [1:0] REF_QUARTER = 2'h1;
  localparam logic [1:0] REF_HALF    = 2'h2;
  localparam logic [1:0] REF_DIODE   = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_CTL_ONE  = 3'b001,
    SEL_CTL_TWO  = 3'b010,
    SEL_PORT_DIS = 3'b011,
    SEL_IRQ_STAT = 3'b100,
    SEL_IRQ_MASK = 3'b101
  } acmp_sel_t;

endpackage : acmp_pkg

// ### core/acmp_sync.sv
`timescale 1ns/1ps
module acmp_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stageOne_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stageOne_reg <= '0;
      syncOut      <= '0;
    end else begin
      stageOne_reg <= asyncIn;
      syncOut      <= stageOne_reg;
    end
  end

endmodule : acmp_sync

// ### core/acmp_ctrl.sv
`timescale 1ns/1ps
module acmp_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Analog comparator outputs, asynchronous
  input  wire logic              cmpRawIn,
  input  wire logic              cmpFiltIn,
  // Analog control
  output logic                   comparatorPowerOn,
  output logic                   inputExchange,
  output logic [1:0]             referenceLevelSelect,
  output logic                   refGenEnable,
  output logic                   refToPositive,
  output logic                   outputFilterEnable,
  output logic                   pinToInputZero,
  output logic                   pinToInputOne,
  output logic [7:0]             pinBufferDisableBits,
  // Processor interrupt side
  input  wire logic              globalIrqEnable,
  input  wire logic              irqServiceAck,
  output logic                   irqRequest,
  output logic                   irqOut,
  // Timer capture
  output logic                   timerCaptureInputB
);

  function automatic acmp_pkg::acmp_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = addr >> 2;
    if (word == ADDR_W'(acmp_pkg::IDX_CTL_ONE))       decodeSel = acmp_pkg::SEL_CTL_ONE;
    else if (word == ADDR_W'(acmp_pkg::IDX_CTL_TWO))  decodeSel = acmp_pkg::SEL_CTL_TWO;
    else if (word == ADDR_W'(acmp_pkg::IDX_PORT_DIS)) decodeSel = acmp_pkg::SEL_PORT_DIS;
    else if (word == ADDR_W'(acmp_pkg::IDX_IRQ_STAT)) decodeSel = acmp_pkg::SEL_IRQ_STAT;
    else if (word == ADDR_W'(acmp_pkg::IDX_IRQ_MASK)) decodeSel = acmp_pkg::SEL_IRQ_MASK;
    else                                               decodeSel = acmp_pkg::SEL_NONE;
  endfunction : decodeSel

  // Synchronised comparator paths
  logic [1:0] cmpSync;
  logic       rawSync;
  logic       filtSync;

  acmp_sync #(
    .W(2)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n   (rst_n),
    .asyncIn ({cmpFiltIn, cmpRawIn}),
    .syncOut (cmpSync)
  );
  assign rawSync  = cmpSync[0];
  assign filtSync = cmpSync[1];

  // Register file state
  logic [7:0] ctlOne_reg,  ctlOne_next;
  logic [7:0] ctlTwo_reg,  ctlTwo_next;
  logic [7:0] portDis_reg, portDis_next;
  logic [7:0] irqStat_reg, irqStat_next;
  logic [7:0] irqMask_reg, irqMask_next;
  logic       refPos_reg,  refPos_next;
  logic       refEn_reg,   refEn_next;
  logic       irqReq_reg,  irqReq_next;
  logic       irqOut_reg,  irqOut_next;

  // Result state
  logic       result_reg,  result_next;
  logic       prevRes_reg, prevRes_next;
  logic       pathSel;
  logic       edgeHit;

  // Bus write state
  logic              awHave_reg,  awHave_next;
  logic              wHave_reg,   wHave_next;
  logic              awReady_reg, awReady_next;
  logic              wReady_reg,  wReady_next;
  logic              bValid_reg,  bValid_next;
  logic [1:0]        bResp_reg,   bResp_next;
  logic [ADDR_W-1:0] awAddr_reg,  awAddr_next;
  logic [31:0]       wData_reg,   wData_next;
  logic [3:0]        wStrb_reg,   wStrb_next;
  logic              doWrite;
  acmp_pkg::acmp_sel_t wSel;

  // Bus read state
  logic        arReady_reg, arReady_next;
  logic        rValid_reg,  rValid_next;
  logic [1:0]  rResp_reg,   rResp_next;
  logic [31:0] rData_reg,   rData_next;
  acmp_pkg::acmp_sel_t rSel;

  assign doWrite = awHave_reg & wHave_reg & ~bValid_reg;
  assign wSel    = decodeSel(awAddr_reg);
  assign rSel    = decodeSel(s_axi_araddr);

  // Write channel: address and data taken in either order
  always_comb begin
    awHave_next = awHave_reg;
    wHave_next  = wHave_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    if (s_axi_awvalid && awReady_reg) begin
      awHave_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_reg) begin
      wHave_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (doWrite) begin
      awHave_next = 1'b0;
      wHave_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = (wSel == acmp_pkg::SEL_NONE) ? acmp_pkg::RESP_DECERR : acmp_pkg::RESP_OKAY;
    end else if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    awReady_next = ~awHave_next & ~bValid_next;
    wReady_next  = ~wHave_next & ~bValid_next;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_reg  <= 1'b0;
      wHave_reg   <= 1'b0;
      awReady_reg <= 1'b1;
      wReady_reg  <= 1'b1;
      bValid_reg  <= 1'b0;
      bResp_reg   <= acmp_pkg::RESP_OKAY;
      awAddr_reg  <= '0;
      wData_reg   <= '0;
      wStrb_reg   <= '0;
    end else begin
      awHave_reg  <= awHave_next;
      wHave_reg   <= wHave_next;
      awReady_reg <= awReady_next;
      wReady_reg  <= wReady_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
    end
  end

  // Read channel: one read at a time, data from current state
  always_comb begin
    arReady_next = arReady_reg;
    rValid_next  = rValid_reg;
    rResp_next   = rResp_reg;
    rData_next   = rData_reg;
    if (s_axi_arvalid && arReady_reg) begin
      arReady_next = 1'b0;
      rValid_next  = 1'b1;
      rResp_next   = acmp_pkg::RESP_OKAY;
      rData_next   = '0;
      unique case (rSel)
        acmp_pkg::SEL_CTL_ONE:  rData_next[7:0] = ctlOne_reg;
        acmp_pkg::SEL_CTL_TWO:  rData_next[7:0] = {ctlTwo_reg[7:1], result_reg};
        acmp_pkg::SEL_PORT_DIS: rData_next[7:0] = portDis_reg;
        acmp_pkg::SEL_IRQ_STAT: rData_next[7:0] = irqStat_reg;
        acmp_pkg::SEL_IRQ_MASK: rData_next[7:0] = irqMask_reg;
        acmp_pkg::SEL_NONE:     rResp_next = acmp_pkg::RESP_DECERR;
      endcase
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next  = 1'b0;
      arReady_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
      rResp_reg   <= acmp_pkg::RESP_OKAY;
      rData_reg   <= '0;
    end else begin
      arReady_reg <= arReady_next;
      rValid_reg  <= rValid_next;
      rResp_reg   <= rResp_next;
      rData_reg   <= rData_next;
    end
  end

  // Result path and edge detection
  always_comb begin
    pathSel = ctlTwo_reg[acmp_pkg::B_FILT] ? filtSync : rawSync;
    // forced low when off, inverted when exchanged
    result_next  = ctlOne_reg[acmp_pkg::B_ON] & (pathSel ^ ctlOne_reg[acmp_pkg::B_EXCH]);
    prevRes_next = result_reg;
    edgeHit = ctlOne_reg[acmp_pkg::B_IES] ? (~result_reg & prevRes_reg)
                                          : (result_reg & ~prevRes_reg);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg  <= 1'b0;
      prevRes_reg <= 1'b0;
    end else begin
      result_reg  <= result_next;
      prevRes_reg <= prevRes_next;
    end
  end

  // Register writes, flag and interrupt logic
  always_comb begin
    ctlOne_next  = ctlOne_reg;
    ctlTwo_next  = ctlTwo_reg;
    portDis_next = portDis_reg;
    irqStat_next = irqStat_reg;
    irqMask_next = irqMask_reg;
    if (doWrite && wStrb_reg[0]) begin
      unique case (wSel)
        acmp_pkg::SEL_CTL_ONE:  ctlOne_next = wData_reg[7:0];
        acmp_pkg::SEL_CTL_TWO:  ctlTwo_next = wData_reg[7:0] & acmp_pkg::CTL_TWO_WMASK;
        acmp_pkg::SEL_PORT_DIS: portDis_next = wData_reg[7:0];
        acmp_pkg::SEL_IRQ_STAT: irqStat_next = irqStat_reg & ~wData_reg[7:0];
        acmp_pkg::SEL_IRQ_MASK: irqMask_next = wData_reg[7:0];
        acmp_pkg::SEL_NONE:     ctlOne_next = ctlOne_reg;
      endcase
    end
    if (irqServiceAck) begin
      ctlOne_next[acmp_pkg::B_FLAG] = 1'b0;
    end
    if (edgeHit) begin
      ctlOne_next[acmp_pkg::B_FLAG]       = 1'b1;
      irqStat_next[acmp_pkg::B_STAT_EDGE] = 1'b1;
    end
    refPos_next = ctlOne_reg[acmp_pkg::B_RSEL] == ctlOne_reg[acmp_pkg::B_EXCH];
    // generator enable from level field only
    refEn_next  = ctlOne_reg[acmp_pkg::B_REF_HI:acmp_pkg::B_REF_LO] != acmp_pkg::REF_OFF;
    irqReq_next = ctlOne_reg[acmp_pkg::B_FLAG] & ctlOne_reg[acmp_pkg::B_IE] & globalIrqEnable;
    irqOut_next = |(irqStat_reg & irqMask_reg);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlOne_reg  <= acmp_pkg::RST_CTL_ONE;
      ctlTwo_reg  <= acmp_pkg::RST_CTL_TWO;
      portDis_reg <= acmp_pkg::RST_PORT_DIS;
      irqStat_reg <= acmp_pkg::RST_IRQ;
      irqMask_reg <= acmp_pkg::RST_IRQ;
      refPos_reg  <= 1'b0;
      refEn_reg   <= 1'b0;
      irqReq_reg  <= 1'b0;
      irqOut_reg  <= 1'b0;
    end else begin
      ctlOne_reg  <= ctlOne_next;
      ctlTwo_reg  <= ctlTwo_next;
      portDis_reg <= portDis_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      refPos_reg  <= refPos_next;
      refEn_reg   <= refEn_next;
      irqReq_reg  <= irqReq_next;
      irqOut_reg  <= irqOut_next;
    end
  end

  assign s_axi_awready        = awReady_reg;
  assign s_axi_wready         = wReady_reg;
  assign s_axi_bvalid         = bValid_reg;
  assign s_axi_bresp          = bResp_reg;
  assign s_axi_arready        = arReady_reg;
  assign s_axi_rvalid         = rValid_reg;
  assign s_axi_rresp          = rResp_reg;
  assign s_axi_rdata          = rData_reg;
  assign comparatorPowerOn    = ctlOne_reg[acmp_pkg::B_ON];
  assign inputExchange        = ctlOne_reg[acmp_pkg::B_EXCH];
  assign referenceLevelSelect = ctlOne_reg[acmp_pkg::B_REF_HI:acmp_pkg::B_REF_LO];
  assign refGenEnable         = refEn_reg;
  assign refToPositive        = refPos_reg;
  assign outputFilterEnable   = ctlTwo_reg[acmp_pkg::B_FILT];
  assign pinToInputZero       = ctlTwo_reg[acmp_pkg::B_PIN_ZERO];
  assign pinToInputOne        = ctlTwo_reg[acmp_pkg::B_PIN_ONE];
  assign pinBufferDisableBits = portDis_reg;
  assign irqRequest           = irqReq_reg;
  assign irqOut               = irqOut_reg;
  assign timerCaptureInputB   = result_reg;

  a_off_forces_low: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !ctlOne_reg[acmp_pkg::B_ON] |=> !result_reg)
    else $error("Result not low while comparator off");

  a_result_readback: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_arvalid && arReady_reg && rSel == acmp_pkg::SEL_CTL_TWO)
      |=> rValid_reg && rData_reg[0] == $past(result_reg))
    else $error("Result bit readback mismatch");

  a_exchange_inverts: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctlOne_reg[acmp_pkg::B_ON] && !ctlTwo_reg[acmp_pkg::B_FILT] && ctlOne_reg[acmp_pkg::B_EXCH])
      |=> result_reg == !$past(rawSync))
    else $error("Exchanged result not inverted");

  a_ref_side: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> refToPositive == ($past(ctlOne_reg[acmp_pkg::B_RSEL]) == $past(inputExchange)))
    else $error("Reference terminal side wrong");

  a_ref_gen_enable: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!comparatorPowerOn && referenceLevelSelect != acmp_pkg::REF_OFF) |=> refGenEnable)
    else $error("Reference generator tied to power bit");

  a_edge_sets_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (result_reg && !prevRes_reg && !ctlOne_reg[acmp_pkg::B_IES]) |=> ctlOne_reg[acmp_pkg::B_FLAG])
    else $error("Rising edge did not set flag");

  a_set_beats_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (edgeHit && irqServiceAck) |=> ctlOne_reg[acmp_pkg::B_FLAG] && irqStat_reg[acmp_pkg::B_STAT_EDGE])
    else $error("Clear beat a same-cycle set");

  a_request_gating: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    irqRequest |-> $past(ctlOne_reg[acmp_pkg::B_FLAG] && ctlOne_reg[acmp_pkg::B_IE] && globalIrqEnable))
    else $error("Request without flag and enables");

  a_service_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (irqServiceAck && !edgeHit) |=> !ctlOne_reg[acmp_pkg::B_FLAG])
    else $error("Service did not clear flag");

  a_filter_path: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctlOne_reg[acmp_pkg::B_ON] && ctlTwo_reg[acmp_pkg::B_FILT] && !ctlOne_reg[acmp_pkg::B_EXCH])
      |=> result_reg == $past(filtSync))
    else $error("Filtered path not selected");

endmodule : acmp_ctrl

// ### testbench/test_analog_comparator_ctrl.sv
`timescale 1ns/1ps
module test_analog_comparator_ctrl;
  localparam logic [7:0] IX_C1 = acmp_pkg::IDX_CTL_ONE;
  localparam logic [7:0] IX_C2 = acmp_pkg::IDX_CTL_TWO;
  localparam logic [7:0] IX_PD = acmp_pkg::IDX_PORT_DIS;
  localparam logic [7:0] IX_ST = acmp_pkg::IDX_IRQ_STAT;
  localparam logic [7:0] IX_MK = acmp_pkg::IDX_IRQ_MASK;
  localparam logic [1:0] OK    = acmp_pkg::RESP_OKAY;

  logic        core_clk, rst_n, awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady, rawIn, filtIn, glbEn, svcAck;
  logic        powerOn, exch, refGen, refPos, filtEn, pinZero, pinOne, irqReq, irqOut, capB;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, rd;
  logic [3:0]  wStrb;
  logic [1:0]  bResp, rResp, refLvl, rs;
  logic [7:0]  pinDis, v;
  int          errCount, numChecks;

  acmp_ctrl u_acmp_ctrl (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .cmpRawIn(rawIn), .cmpFiltIn(filtIn),
    .comparatorPowerOn(powerOn), .inputExchange(exch), .referenceLevelSelect(refLvl),
    .refGenEnable(refGen), .refToPositive(refPos), .outputFilterEnable(filtEn),
    .pinToInputZero(pinZero), .pinToInputOne(pinOne), .pinBufferDisableBits(pinDis),
    .globalIrqEnable(glbEn), .irqServiceAck(svcAck), .irqRequest(irqReq),
    .irqOut(irqOut), .timerCaptureInputB(capB)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      errCount++;
    end
  endtask : check

  task automatic report_and_stop;
    if (errCount == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic settle;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  // Ready is registered, so its level at the falling edge holds for the next rising edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aP, wP, tA, tW;
    int   n;
    aP = 1'b1;
    wP = 1'b1;
    n = 0;
    @(posedge core_clk);
    awAddr <= {2'h0, idx, 2'h0};
    awValid <= 1'b1;
    wData <= {24'h0, d};
    wValid <= 1'b1;
    bReady <= 1'b1;
    while ((aP || wP) && n < 50) begin
      @(negedge core_clk);
      tA = aP && awReady === 1'b1;
      tW = wP && wReady === 1'b1;
      @(posedge core_clk);
      if (tA) awValid <= 1'b0;
      if (tA) aP = 1'b0;
      if (tW) wValid <= 1'b0;
      if (tW) wP = 1'b0;
      n++;
    end
    do begin
      @(negedge core_clk);
      n++;
    end while (bValid !== 1'b1 && n < 100);
    check("write response", 32'(bResp), 32'(er));
    @(posedge core_clk);
    bReady <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    arAddr <= {2'h0, idx, 2'h0};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (arReady !== 1'b1 && n < 50);
    @(posedge core_clk);
    arValid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rValid !== 1'b1 && n < 100);
    d = rData;
    r = rResp;
    @(posedge core_clk);
    rReady <= 1'b0;
  endtask : rdr

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] e);
    rdr(idx, rd, rs);
    check(what, rd, {24'h0, e});
    check("read response", 32'(rs), 32'(OK));
  endtask : rchk

  // Comparator input change needs three edges to reach the result and one more for the flag
  task automatic drive(input logic r, input logic f);
    @(posedge core_clk);
    rawIn <= r;
    filtIn <= f;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask : drive

  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      rchk("reset value", IX_C1 + 8'(i), 8'h00);
    end
    check("outputs at reset", 32'({powerOn, exch, refLvl, refGen, filtEn, pinZero, pinOne,
          pinDis, irqReq, irqOut, capB}), 32'h0);
  endtask : t_reset

  task automatic t_ctl_one;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[1], i[2:1], 4'h0};
      wr(IX_C1, v, OK);
      settle();
      check("reference level", 32'(refLvl), 32'(v[5:4]));
      check("reference enable", 32'(refGen), 32'(v[5:4] != 2'h0));
      check("reference terminal", 32'(refPos), 32'(v[6] == v[7]));
      check("exchange", 32'(exch), 32'(v[7]));
      rchk("control one", IX_C1, v);
    end
  endtask : t_ctl_one

  task automatic t_ctl_two;
    wr(IX_C2, 8'hff, OK);
    settle();
    check("pins and filter", 32'({pinOne, pinZero, filtEn}), 32'h7);
    rchk("control two", IX_C2, 8'hfe);
    wr(IX_C2, 8'h04, OK);
    settle();
    check("pins and filter", 32'({pinOne, pinZero, filtEn}), 32'h2);
    wr(IX_C2, 8'h00, OK);
  endtask : t_ctl_two

  task automatic t_port;
    wr(IX_PD, 8'ha5, OK);
    settle();
    check("buffer disable", 32'(pinDis), 32'ha5);
    rchk("port disable", IX_PD, 8'ha5);
    wr(IX_PD, 8'h5a, OK);
    settle();
    check("buffer disable", 32'(pinDis), 32'h5a);
  endtask : t_port

  task automatic t_result;
    logic e;
    for (int i = 0; i < 16; i++) begin
      wr(IX_C1, {i[2], 3'h0, i[3], 3'h0}, OK);
      wr(IX_C2, {6'h0, i[1], 1'b0}, OK);
      drive(i[0], ~i[0]);
      e = i[3] & ((i[1] ? ~i[0] : i[0]) ^ i[2]);
      check("power on", 32'(powerOn), 32'(i[3]));
      check("capture input", 32'(capB), 32'(e));
      rchk("result bit", IX_C2, {6'h0, i[1], e});
    end
    wr(IX_C2, 8'h00, OK);
  endtask : t_result

  task automatic t_irq;
    wr(IX_C1, 8'h0a, OK);
    wr(IX_MK, 8'h01, OK);
    drive(1'b0, 1'b0);
    wr(IX_C1, 8'h0a, OK);
    wr(IX_ST, 8'hff, OK);
    @(posedge core_clk);
    glbEn <= 1'b1;
    drive(1'b1, 1'b0);
    check("request on rise", 32'(irqReq), 32'h1);
    check("level interrupt", 32'(irqOut), 32'h1);
    rchk("flag on rise", IX_C1, 8'h0b);
    @(posedge core_clk);
    svcAck <= 1'b1;
    @(posedge core_clk);
    svcAck <= 1'b0;
    settle();
    check("request after service", 32'(irqReq), 32'h0);
    check("status kept", 32'(irqOut), 32'h1);
    rchk("flag after service", IX_C1, 8'h0a);
    drive(1'b0, 1'b0);
    rchk("no flag on fall", IX_C1, 8'h0a);
    wr(IX_ST, 8'h01, OK);
    settle();
    check("status cleared", 32'(irqOut), 32'h0);
    wr(IX_C1, 8'h0e, OK);
    drive(1'b1, 1'b0);
    rchk("no flag on rise", IX_C1, 8'h0e);
    drive(1'b0, 1'b0);
    rchk("flag on fall", IX_C1, 8'h0f);
    check("request on fall", 32'(irqReq), 32'h1);
    @(posedge core_clk);
    glbEn <= 1'b0;
    settle();
    check("global disabled", 32'(irqReq), 32'h0);
    @(posedge core_clk);
    glbEn <= 1'b1;
    wr(IX_C1, 8'h0c, OK);
    settle();
    check("local disabled", 32'(irqReq), 32'h0);
    rchk("software clear", IX_C1, 8'h0c);
    check("masked status", 32'(irqOut), 32'h1);
    wr(IX_MK, 8'h00, OK);
    settle();
    check("masked status", 32'(irqOut), 32'h0);
    wr(IX_C1, 8'h0a, OK);
    // Service pulse lands on the edge that sets the flag
    @(posedge core_clk);
    rawIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    svcAck <= 1'b1;
    @(posedge core_clk);
    svcAck <= 1'b0;
    settle();
    rchk("set beats service", IX_C1, 8'h0b);
  endtask : t_irq

  task automatic t_unmapped;
    wr(8'h60, 8'h55, acmp_pkg::RESP_DECERR);
    rdr(8'h60, rd, rs);
    check("unmapped data", rd, 32'h0);
    check("unmapped response", 32'(rs), 32'(acmp_pkg::RESP_DECERR));
    // Write without byte zero strobe leaves the register alone
    @(posedge core_clk);
    wStrb <= 4'h0;
    wr(IX_PD, 8'hff, OK);
    rchk("strobe off", IX_PD, 8'h5a);
    @(posedge core_clk);
    wStrb <= 4'h1;
  endtask : t_unmapped

  initial begin
    rst_n = 1'b0;
    {awValid, wValid, bReady, arValid, rReady, rawIn, filtIn, glbEn, svcAck} = '0;
    awAddr = '0;
    arAddr = '0;
    wData = '0;
    wStrb = 4'h1;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctl_one();
    t_ctl_two();
    t_port();
    t_result();
    t_irq();
    t_unmapped();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    report_and_stop();
  end
endmodule : test_analog_comparator_ctrl
